// >>> design/mad_decoder.sv
`timescale 1ns/1ps
// main: memory address decoder registering one-hot target selects and the reset fetch address
// What this block does
// - top range goes to external bus
// - program memory from 2080 to variant top
// - 2000-207F is special-purpose memory
// - peripheral sfrs 1F00-1FDF, mapped sfrs above
// - 1C00-1EFF forwarded to external bus
// - code ram or external at 0400-05FF
// - upper register file up to variant limit
// - 0000-00FF lower file, only direct region
// - first fetch after reset at 2080
module mad_decoder (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic                ce,
	input  wire logic                big_var,
	input  wire mad_pkg::mad_req_t   req,
	output mad_pkg::mad_sel_t        sel_out_reg,
	output logic [mad_pkg::ADDR_W-1:0] fetch_addr_reg,
	output logic                     first_fetch_reg
);

	logic [mad_pkg::NTGT-1:0] sel_w;
	logic                     direct_ok;
	logic                     window_ok;

	// range decode leaf; purely combinational so the select is ready within the request cycle
	mad_region u_region (
		.big_var   (big_var),
		.addr      (req.addr),
		.sel       (sel_w),
		.direct_ok (direct_ok),
		.window_ok (window_ok)
	);

	// a mode the region cannot take is flagged; the select still names the region so the core can fault
	wire mode_direct = req.mode == mad_pkg::MODE_DIRECT;
	wire mode_window = req.mode == mad_pkg::MODE_WINDOWED;
	wire direct_bad  = mode_direct && !direct_ok;
	wire window_bad  = mode_window && !window_ok;
	wire mode_bad    = direct_bad || window_bad;

	// next answer; idle cycles still carry the address, only valid, mode_err and the selects drop
	mad_pkg::mad_sel_t sel_next;
	assign sel_next.valid    = req.valid;
	assign sel_next.mode_err = req.valid & mode_bad;
	assign sel_next.sel      = req.valid ? sel_w : '0;
	assign sel_next.addr     = req.addr;

	// fetch pointer state: after reset it names the reset vector until the first fetch is taken
	typedef enum logic [0:0] {
		ST_BOOT = 1'b0,
		ST_RUN  = 1'b1
	} mad_st_t;

	mad_st_t st_reg;
	mad_st_t st_next;
	wire fetch_taken = req.valid & req.fetch;

	always_comb begin
		case (st_reg)
			ST_BOOT: st_next = fetch_taken ? ST_RUN : ST_BOOT;
			ST_RUN:  st_next = ST_RUN;
			default: st_next = ST_BOOT;
		endcase
	end

	// pointer follows taken fetches only, so plain data accesses never move it
	wire [15:0] fetch_next = fetch_taken ? req.addr : fetch_addr_reg;

	// select register; outputs come straight from flops, one cycle after the request
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sel_out_reg <= '0;
		end else if (ce) begin
			sel_out_reg <= sel_next;
		end
	end

	// reset vector and boot flag
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_reg          <= ST_BOOT;
			fetch_addr_reg  <= mad_pkg::RESET_FETCH;
			first_fetch_reg <= 1'b1;
		end else if (ce) begin
			st_reg          <= st_next;
			fetch_addr_reg  <= fetch_next;
			first_fetch_reg <= (st_next == ST_BOOT);
		end
	end

	// select shape: one target per valid answer, nothing on idle cycles
	a_one_hot_sel: assert property (@(posedge clk) disable iff (!rstn)
		sel_out_reg.valid |-> $onehot(sel_out_reg.sel))
		else $error("target select not one-hot");
	a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
		!sel_out_reg.valid |-> sel_out_reg.sel == '0 && !sel_out_reg.mode_err)
		else $error("idle cycle drives a select");
	a_addr_echo: assert property (@(posedge clk) disable iff (!rstn)
		rstn && ce |=> sel_out_reg.addr == $past(req.addr) && sel_out_reg.valid == $past(req.valid))
		else $error("address not carried with select");

	// every select bit needs a valid answer behind it
	for (genvar g = 0; g < mad_pkg::NTGT; g++) begin : g_sel_chk
		a_sel_valid: assert property (@(posedge clk) disable iff (!rstn)
			sel_out_reg.sel[g] |-> sel_out_reg.valid)
			else $error("select without valid answer");
	end

	// range decode, one property per region, answer one cycle after the request
	a_lower_file: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && req.addr <= mad_pkg::LREG_HI |=> sel_out_reg.sel[mad_pkg::T_LREG])
		else $error("lower file not selected");
	a_upper_file: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && req.addr >= mad_pkg::UREG_LO &&
		req.addr <= (big_var ? mad_pkg::UREG_HI_BIG : mad_pkg::UREG_HI_SML)
		|=> sel_out_reg.sel[mad_pkg::T_UREG])
		else $error("upper file not selected");
	a_code_ram: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && req.addr >= mad_pkg::CRAM_LO && req.addr <= mad_pkg::CRAM_HI
		|=> sel_out_reg.sel[big_var ? mad_pkg::T_CRAM : mad_pkg::T_EXT])
		else $error("code ram region misrouted");
	a_small_low_ext: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && !big_var && req.addr >= mad_pkg::XLO_LO_SML && req.addr <= mad_pkg::CRAM_HI
		|=> sel_out_reg.sel[mad_pkg::T_EXT])
		else $error("small variant low hole not external");
	a_cram_small_off: assert property (@(posedge clk) disable iff (!rstn)
		!big_var |-> !sel_out_reg.sel[mad_pkg::T_CRAM])
		else $error("code ram selected on small variant");
	a_mid_ext: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && req.addr >= mad_pkg::XMID_LO && req.addr <= mad_pkg::XMID_HI
		|=> sel_out_reg.sel[mad_pkg::T_EXT])
		else $error("middle range not external");
	a_rsv_ext: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && req.addr >= mad_pkg::XRSV_LO && req.addr <= mad_pkg::XRSV_HI
		|=> sel_out_reg.sel[mad_pkg::T_EXT])
		else $error("reserved range not external");
	a_sfr_decode: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && req.addr >= mad_pkg::PSFR_LO && req.addr <= mad_pkg::PSFR_HI
		|=> sel_out_reg.sel[mad_pkg::T_PSFR] &&
		sel_out_reg.mode_err == ($past(req.mode) == mad_pkg::MODE_DIRECT))
		else $error("peripheral sfr misdecoded");
	a_msfr_decode: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && req.addr >= mad_pkg::MSFR_LO && req.addr <= mad_pkg::MSFR_HI
		|=> sel_out_reg.sel[mad_pkg::T_MSFR])
		else $error("mapped sfr not selected");
	a_spm_decode: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && req.addr >= mad_pkg::SPM_LO && req.addr <= mad_pkg::SPM_HI
		|=> sel_out_reg.sel[mad_pkg::T_SPM])
		else $error("special memory not selected");
	a_prog_decode: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && req.addr >= mad_pkg::PROG_LO &&
		req.addr <= (big_var ? mad_pkg::PROG_HI_BIG : mad_pkg::PROG_HI_SML)
		|=> sel_out_reg.sel[mad_pkg::T_PROG])
		else $error("program memory not selected");
	a_top_ext: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && req.addr >= (big_var ? mad_pkg::XTOP_LO_BIG : mad_pkg::XTOP_LO_SML)
		|=> sel_out_reg.sel[mad_pkg::T_EXT])
		else $error("top range not external");

	// reverse direction: a select never names an address outside its region
	a_lower_bound: assert property (@(posedge clk) disable iff (!rstn)
		sel_out_reg.sel[mad_pkg::T_LREG] |-> sel_out_reg.addr <= mad_pkg::LREG_HI)
		else $error("lower file selected out of range");
	a_ext_low_bound: assert property (@(posedge clk) disable iff (!rstn)
		sel_out_reg.sel[mad_pkg::T_EXT] |-> sel_out_reg.addr >= (big_var ? mad_pkg::XMID_LO : mad_pkg::XLO_LO_SML))
		else $error("external selected below its range");
	a_spm_bound: assert property (@(posedge clk) disable iff (!rstn)
		sel_out_reg.sel[mad_pkg::T_SPM] |-> sel_out_reg.addr >= mad_pkg::SPM_LO && sel_out_reg.addr <= mad_pkg::SPM_HI)
		else $error("special memory selected out of range");
	a_prog_bound: assert property (@(posedge clk) disable iff (!rstn)
		sel_out_reg.sel[mad_pkg::T_PROG] |-> sel_out_reg.addr >= mad_pkg::PROG_LO)
		else $error("program memory selected below its range");

	// addressing modes: plain direct only below 0100, windowed direct only upper file and peripheral sfrs
	a_direct_lower: assert property (@(posedge clk) disable iff (!rstn)
		rstn && ce && req.valid && req.mode == mad_pkg::MODE_DIRECT
		|=> sel_out_reg.mode_err == !sel_out_reg.sel[mad_pkg::T_LREG])
		else $error("direct mode check wrong");
	a_window_regions: assert property (@(posedge clk) disable iff (!rstn)
		rstn && ce && req.valid && req.mode == mad_pkg::MODE_WINDOWED
		|=> sel_out_reg.mode_err ==
		!(sel_out_reg.sel[mad_pkg::T_UREG] || sel_out_reg.sel[mad_pkg::T_PSFR]))
		else $error("windowed mode check wrong");
	a_indirect_any: assert property (@(posedge clk) disable iff (!rstn)
		rstn && ce && req.valid && (req.mode == mad_pkg::MODE_INDIRECT || req.mode == mad_pkg::MODE_INDEXED)
		|=> !sel_out_reg.mode_err)
		else $error("indirect or indexed access refused");

	// clock enable low holds every flop; reset still acts, the disable covers that case
	a_ce_freeze: assert property (@(posedge clk) disable iff (!rstn)
		rstn && !ce
		|=> $stable(sel_out_reg) && $stable(fetch_addr_reg) && $stable(first_fetch_reg))
		else $error("state moved with clock enable low");

	// fetch pointer: reset vector until the first fetch, then the last fetch address
	a_reset_vec: assert property (@(posedge clk)
		$rose(rstn) |-> fetch_addr_reg == mad_pkg::RESET_FETCH && first_fetch_reg)
		else $error("reset fetch address wrong");
	a_boot_vec: assert property (@(posedge clk) disable iff (!rstn)
		first_fetch_reg |-> fetch_addr_reg == mad_pkg::RESET_FETCH)
		else $error("boot pointer left reset vector");
	a_fetch_load: assert property (@(posedge clk) disable iff (!rstn)
		rstn && ce && req.valid && req.fetch
		|=> fetch_addr_reg == $past(req.addr) && !first_fetch_reg)
		else $error("fetch address not taken");
	a_fetch_hold: assert property (@(posedge clk) disable iff (!rstn)
		rstn && ce && !(req.valid && req.fetch) |=> $stable(fetch_addr_reg))
		else $error("fetch pointer moved without fetch");
	a_first_hold: assert property (@(posedge clk) disable iff (!rstn)
		rstn && ce && first_fetch_reg && !(req.valid && req.fetch) |=> first_fetch_reg)
		else $error("boot flag dropped without fetch");
	a_run_stays: assert property (@(posedge clk) disable iff (!rstn)
		rstn && !first_fetch_reg |=> !first_fetch_reg)
		else $error("boot flag came back without reset");

	// main scenarios seen at least once
	c_ext_access: cover property (@(posedge clk) disable iff (!rstn) sel_out_reg.sel[mad_pkg::T_EXT]);
	c_boot_fetch: cover property (@(posedge clk) disable iff (!rstn) first_fetch_reg ##1 !first_fetch_reg);
	c_mode_err:   cover property (@(posedge clk) disable iff (!rstn) sel_out_reg.mode_err);
	c_window_sfr: cover property (@(posedge clk) disable iff (!rstn)
		ce && req.valid && req.mode == mad_pkg::MODE_WINDOWED ##1 sel_out_reg.sel[mad_pkg::T_PSFR] && !sel_out_reg.mode_err);
	c_small_hole: cover property (@(posedge clk) disable iff (!rstn)
		!big_var && sel_out_reg.valid && sel_out_reg.addr == mad_pkg::CRAM_LO);

endmodule

// >>> design/mad_pkg.sv
// package: address map constants, target encoding and access types for the memory address decoder
package mad_pkg;

	localparam int ADDR_W = 16;

	// region bounds, both variants
	localparam logic [15:0] LREG_LO     = 16'h0000;
	localparam logic [15:0] LREG_HI     = 16'h00FF;
	localparam logic [15:0] UREG_LO     = 16'h0100;
	localparam logic [15:0] UREG_HI_BIG = 16'h03FF;
	localparam logic [15:0] UREG_HI_SML = 16'h017F;
	localparam logic [15:0] XLO_LO_SML  = 16'h0180;
	localparam logic [15:0] CRAM_LO     = 16'h0400;
	localparam logic [15:0] CRAM_HI     = 16'h05FF;
	localparam logic [15:0] XMID_LO     = 16'h0600;
	localparam logic [15:0] XMID_HI     = 16'h1BFF;
	localparam logic [15:0] XRSV_LO     = 16'h1C00;
	localparam logic [15:0] XRSV_HI     = 16'h1EFF;
	localparam logic [15:0] PSFR_LO     = 16'h1F00;
	localparam logic [15:0] PSFR_HI     = 16'h1FDF;
	localparam logic [15:0] MSFR_LO     = 16'h1FE0;
	localparam logic [15:0] MSFR_HI     = 16'h1FFF;
	localparam logic [15:0] SPM_LO      = 16'h2000;
	localparam logic [15:0] SPM_HI      = 16'h207F;
	localparam logic [15:0] PROG_LO     = 16'h2080;
	localparam logic [15:0] PROG_HI_BIG = 16'h9FFF;
	localparam logic [15:0] PROG_HI_SML = 16'h5FFF;
	localparam logic [15:0] XTOP_LO_BIG = 16'hA000;
	localparam logic [15:0] XTOP_LO_SML = 16'h6000;
	localparam logic [15:0] XTOP_HI     = 16'hFFFF;

	// first fetch after reset
	localparam logic [15:0] RESET_FETCH = 16'h2080;

	localparam int NTGT = 8;

	// one-hot target select bit positions
	localparam int T_LREG = 0;
	localparam int T_UREG = 1;
	localparam int T_CRAM = 2;
	localparam int T_PSFR = 3;
	localparam int T_MSFR = 4;
	localparam int T_SPM  = 5;
	localparam int T_PROG = 6;
	localparam int T_EXT  = 7;

	// addressing mode of a core access
	typedef enum logic [1:0] {
		MODE_DIRECT   = 2'h0,
		MODE_INDIRECT = 2'h1,
		MODE_INDEXED  = 2'h2,
		MODE_WINDOWED = 2'h3
	} mad_mode_t;

	// request issued by the core
	typedef struct packed {
		logic        valid;
		logic        fetch;
		mad_mode_t   mode;
		logic [15:0] addr;
	} mad_req_t;

	// decoded answer toward the targets
	typedef struct packed {
		logic            valid;
		logic            mode_err;
		logic [NTGT-1:0] sel;
		logic [15:0]     addr;
	} mad_sel_t;

endpackage

// >>> design/mad_region.sv
`timescale 1ns/1ps
// leaf: purely combinational range decode of one address into a one-hot target select
module mad_region (
	input  wire logic                      big_var,
	input  wire logic [mad_pkg::ADDR_W-1:0] addr,
	output logic      [mad_pkg::NTGT-1:0]   sel,
	output logic                           direct_ok,
	output logic                           window_ok
);

	// variant-dependent bounds picked once
	wire [15:0] ureg_hi = big_var ? mad_pkg::UREG_HI_BIG : mad_pkg::UREG_HI_SML;
	wire [15:0] prog_hi = big_var ? mad_pkg::PROG_HI_BIG : mad_pkg::PROG_HI_SML;
	wire [15:0] xtop_lo = big_var ? mad_pkg::XTOP_LO_BIG : mad_pkg::XTOP_LO_SML;

	// range hits; ranges are disjoint so at most one can fire
	wire in_lreg = addr <= mad_pkg::LREG_HI;
	wire in_ureg = addr >= mad_pkg::UREG_LO && addr <= ureg_hi;
	wire in_cram = big_var && addr >= mad_pkg::CRAM_LO && addr <= mad_pkg::CRAM_HI;
	wire in_xlo  = !big_var && addr >= mad_pkg::XLO_LO_SML && addr <= mad_pkg::CRAM_HI;
	wire in_xmid = addr >= mad_pkg::XMID_LO && addr <= mad_pkg::XMID_HI;
	wire in_xrsv = addr >= mad_pkg::XRSV_LO && addr <= mad_pkg::XRSV_HI;
	wire in_psfr = addr >= mad_pkg::PSFR_LO && addr <= mad_pkg::PSFR_HI;
	wire in_msfr = addr >= mad_pkg::MSFR_LO && addr <= mad_pkg::MSFR_HI;
	wire in_spm  = addr >= mad_pkg::SPM_LO && addr <= mad_pkg::SPM_HI;
	wire in_prog = addr >= mad_pkg::PROG_LO && addr <= prog_hi;
	wire in_xtop = addr >= xtop_lo;

	// the 0180-05FF hole on the smaller variant is sent outside; together the ranges tile 64K
	assign sel[mad_pkg::T_LREG] = in_lreg;
	assign sel[mad_pkg::T_UREG] = in_ureg;
	assign sel[mad_pkg::T_CRAM] = in_cram;
	assign sel[mad_pkg::T_PSFR] = in_psfr;
	assign sel[mad_pkg::T_MSFR] = in_msfr;
	assign sel[mad_pkg::T_SPM]  = in_spm;
	assign sel[mad_pkg::T_PROG] = in_prog;
	assign sel[mad_pkg::T_EXT]  = in_xtop | in_xrsv | in_xmid | in_xlo;

	// plain direct only in the lower file; windowed direct for upper file and peripheral sfrs
	assign direct_ok = in_lreg;
	assign window_ok = in_ureg | in_psfr;

endmodule

// >>> testbench/mad_core_model.sv
`timescale 1ns/1ps
// partner: core side issuing one decoder request per strobe
module mad_core_model (
	input  wire logic               go,
	input  wire logic               fetch,
	input  wire mad_pkg::mad_mode_t mode,
	input  wire logic [15:0]        addr,
	output mad_pkg::mad_req_t       req
);
	// a deselected core shows the inverse address so a stale value is never mistaken for a request
	assign req = go ? {1'b1, fetch, mode, addr} : {1'b0, 1'b0, mad_pkg::MODE_DIRECT, ~addr};
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
// bench: boundary sweep of both maps, mode checks, reset fetch and clock enable
module tb;
	logic               clk = 1'b0;
	logic               rstn = 1'b0;
	logic               ce = 1'b1;
	logic               big_var = 1'b1;
	logic               go = 1'b0;
	logic               fetch = 1'b0;
	mad_pkg::mad_mode_t mode = mad_pkg::MODE_INDIRECT;
	logic [15:0]        addr = 16'h0000;
	mad_pkg::mad_req_t  req;
	mad_pkg::mad_sel_t  sel_out_reg;
	logic [15:0]        fetch_addr_reg;
	logic               first_fetch_reg;
	int                 mismatches = 0;
	int                 n_compared = 0;
	logic [15:0]        edges [24] = '{16'h0000, 16'h00FF, 16'h0100, 16'h017F, 16'h0180, 16'h03FF, 16'h0400,
		16'h05FF, 16'h0600, 16'h1BFF, 16'h1C00, 16'h1EFF, 16'h1F00, 16'h1FDF, 16'h1FE0, 16'h1FFF, 16'h2000,
		16'h207F, 16'h2080, 16'h5FFF, 16'h6000, 16'h9FFF, 16'hA000, 16'hFFFF};
	always #12.5 clk = ~clk;
	mad_core_model mad_core_model_i (.go(go), .fetch(fetch), .mode(mode), .addr(addr), .req(req));
	mad_decoder mad_decoder_i (.clk(clk), .rstn(rstn), .ce(ce), .big_var(big_var), .req(req),
		.sel_out_reg(sel_out_reg), .fetch_addr_reg(fetch_addr_reg), .first_fetch_reg(first_fetch_reg));
	task automatic chk(input string name, input logic [25:0] exp, input logic [25:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// expected target bit worked out from the address map of each variant
	function automatic int exp_bit(input logic big, input logic [15:0] a);
		if (a <= 16'h00FF) return 0;
		if (a <= (big ? 16'h03FF : 16'h017F)) return 1;
		if (big && a >= 16'h0400 && a <= 16'h05FF) return 2;
		if (a < 16'h1F00) return 7;
		if (a <= 16'h1FDF) return 3;
		if (a <= 16'h1FFF) return 4;
		if (a <= 16'h207F) return 5;
		if (a <= (big ? 16'h9FFF : 16'h5FFF)) return 6;
		return 7;
	endfunction
	task automatic issue(input logic f, input mad_pkg::mad_mode_t m, input logic [15:0] a);
		@(posedge clk);
		fetch <= f;
		mode <= m;
		addr <= a;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		#1;
	endtask
	task automatic do_reset(input logic big);
		@(posedge clk);
		rstn <= 1'b0;
		big_var <= big;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		#1;
		chk("sel after reset", 26'h0, sel_out_reg);
		chk("fetch after reset", {10'h0, 16'h2080}, {10'h0, fetch_addr_reg});
		chk("first flag after reset", 26'h1, {25'h0, first_fetch_reg});
	endtask
	// every boundary in every mode; one-hot select and mode error per region
	task automatic sweep(input logic big);
		int b;
		logic e;
		do_reset(big);
		foreach (edges[i]) begin
			for (int m = 0; m < 4; m++) begin
				b = exp_bit(big, edges[i]);
				e = (m == 0 && b != 0) || (m == 3 && b != 1 && b != 3);
				issue(1'b0, mad_pkg::mad_mode_t'(m), edges[i]);
				chk("decode", {1'b1, e, 8'h01 << b, edges[i]}, sel_out_reg);
			end
		end
	endtask
	// fetches, idle cycle, frozen clock enable and a second reset
	task automatic fetch_test;
		do_reset(1'b1);
		issue(1'b0, mad_pkg::MODE_INDIRECT, 16'h3000);
		chk("boot flag before fetch", 26'h1, {25'h0, first_fetch_reg});
		chk("boot addr before fetch", {10'h0, 16'h2080}, {10'h0, fetch_addr_reg});
		issue(1'b1, mad_pkg::MODE_INDEXED, 16'h2080);
		chk("first fetch flag", 26'h0, {25'h0, first_fetch_reg});
		chk("fetch addr", {10'h0, 16'h2080}, {10'h0, fetch_addr_reg});
		issue(1'b1, mad_pkg::MODE_INDEXED, 16'h3000);
		chk("fetch addr next", {10'h0, 16'h3000}, {10'h0, fetch_addr_reg});
		// idle cycle carries the inverse of the last address; then freeze with a fetch pending
		@(posedge clk);
		ce <= 1'b0;
		#1;
		chk("idle select", {2'b00, 8'h00, 16'hCFFF}, sel_out_reg);
		issue(1'b1, mad_pkg::MODE_INDIRECT, 16'h1F10);
		chk("frozen select", {2'b00, 8'h00, 16'hCFFF}, sel_out_reg);
		chk("frozen fetch addr", {10'h0, 16'h3000}, {10'h0, fetch_addr_reg});
		@(posedge clk);
		ce <= 1'b1;
		issue(1'b0, mad_pkg::MODE_INDIRECT, 16'h1F10);
		chk("sfr select", {2'b10, 8'h08, 16'h1F10}, sel_out_reg);
		// reset must act with clock enable low as well
		@(posedge clk);
		ce <= 1'b0;
		do_reset(1'b0);
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		sweep(1'b1);
		sweep(1'b0);
		fetch_test();
		stop_test();
	end
	// watchdog: the sweeps take well under 2000 cycles
	initial begin
		#(25 * 5000);
		mismatches++;
		stop_test();
	end
endmodule
